// ---- kwu_top.sv ----
// keypad wake unit: pin edge/level trigger logic behind an APB register slave
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module kwu_top
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [7:0]  KEY_I,
  input  wire logic        STOP_I,
  output logic             REQ_O,
  output logic             WAKE_O,
  output logic             IRQ_O
);

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == kwu_pkg::OFS_SC) || (a == kwu_pkg::OFS_PE) ||
               (a == kwu_pkg::OFS_EVT) || (a == kwu_pkg::OFS_MSK);
  endfunction

  // asserted level of each pin; pins 3:0 are always active low
  function automatic logic [7:0] asserted(input logic [7:0] pins, input logic [3:0] pol);
    asserted = {pins[7:4] ~^ pol, ~pins[3:0]};
  endfunction

  logic [3:0]  pol_ff;
  logic        ien_ff;
  logic        mode_ff;
  logic        pend_ff;
  logic [7:0]  pe_ff;
  logic [1:0]  evt_ff;
  logic [1:0]  msk_ff;
  logic [7:0]  asrt_prev_ff;
  logic [31:0] prdata_ff;
  logic        rd_held_ff;

  logic        setup;
  logic        wr_en;
  logic        sc_wr;
  logic        ack_wr;
  logic        rd_take;
  logic        rd_done;
  logic [7:0]  asrt;
  logic        any_prev;
  logic        edge_hit;
  logic        level_hit;
  logic        pend_set;
  logic        nxt_pend;
  logic [1:0]  evt_set;
  logic [1:0]  nxt_evt;
  logic [31:0] nxt_rdata;

  // apb slave: writes take no wait state, a read waits until its data is latched
  assign setup     = PSEL_I && !PENABLE_I;
  assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
  assign sc_wr     = wr_en && (PADDR_I == kwu_pkg::OFS_SC);
  assign ack_wr    = sc_wr && PWDATA_I[kwu_pkg::SC_ACK];
  assign rd_take   = CE_I && PSEL_I && !PWRITE_I && !(PENABLE_I && rd_held_ff);
  assign rd_done   = CE_I && PSEL_I && PENABLE_I && !PWRITE_I && rd_held_ff;
  assign PREADY_O  = CE_I && (PWRITE_I || !PENABLE_I || rd_held_ff);
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit(PADDR_I);
  assign PRDATA_O  = prdata_ff;

  // disabled pins read as deasserted
  assign asrt      = asserted(KEY_I, pol_ff) & pe_ff;
  assign any_prev  = |asrt_prev_ff;

  // rising or falling edge: deasserted last cycle, asserted now
  always_comb
  begin
    if (STOP_I)
      edge_hit = 1'b0;
    else if (mode_ff)
      edge_hit = |asrt && !any_prev;
    else
      edge_hit = |(asrt & ~asrt_prev_ff);
  end

  assign level_hit = mode_ff && |asrt && !STOP_I;
  assign pend_set  = edge_hit || level_hit;

  // a set in the same cycle as an acknowledge wins
  always_comb
  begin
    nxt_pend = pend_ff;
    if (ack_wr)
      nxt_pend = 1'b0;
    if (pend_set)
      nxt_pend = 1'b1;
  end

  // stop mode wake is combinational so it works with the clock halted
  assign WAKE_O = STOP_I && |asrt;
  assign REQ_O  = pend_ff && ien_ff;
  assign IRQ_O  = |(evt_ff & msk_ff);

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      asrt_prev_ff <= 8'h00;
    else if (CE_I)
      asrt_prev_ff <= asrt;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      pend_ff <= 1'b0;
    else if (CE_I)
      pend_ff <= nxt_pend;
  end

  // status/control writable fields
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      pol_ff  <= kwu_pkg::RST_POL;
      ien_ff  <= 1'b0;
      mode_ff <= 1'b0;
    end
    else if (sc_wr)
    begin
      pol_ff  <= PWDATA_I[kwu_pkg::SC_POL_MSB:kwu_pkg::SC_POL_LSB];
      ien_ff  <= PWDATA_I[kwu_pkg::SC_IEN];
      mode_ff <= PWDATA_I[kwu_pkg::SC_MODE];
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      pe_ff <= kwu_pkg::RST_PE;
    else if (wr_en && (PADDR_I == kwu_pkg::OFS_PE))
      pe_ff <= PWDATA_I[7:0];
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      msk_ff <= kwu_pkg::RST_MSK;
    else if (wr_en && (PADDR_I == kwu_pkg::OFS_MSK))
      msk_ff <= PWDATA_I[1:0];
  end

  // sticky events, write one to clear, set wins over clear
  assign evt_set = {WAKE_O, pend_set && !pend_ff};

  always_comb
  begin
    nxt_evt = evt_ff;
    if (wr_en && (PADDR_I == kwu_pkg::OFS_EVT))
      nxt_evt = evt_ff & ~PWDATA_I[1:0];
    nxt_evt = nxt_evt | evt_set;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      evt_ff <= kwu_pkg::RST_EVT;
    else if (CE_I)
      evt_ff <= nxt_evt;
  end

  // a setup frozen by a low clock enable latched nothing, so the access waits a cycle
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      rd_held_ff <= 1'b0;
    else if (CE_I)
    begin
      if (rd_take)
        rd_held_ff <= 1'b1;
      else if (rd_done || !PSEL_I)
        rd_held_ff <= 1'b0;
    end
  end

  // read data captured before the access cycle answers
  always_comb
  begin
    nxt_rdata = kwu_pkg::RST_RDATA;
    case (PADDR_I)
      kwu_pkg::OFS_SC:
      begin
        nxt_rdata[kwu_pkg::SC_POL_MSB:kwu_pkg::SC_POL_LSB] = pol_ff;
        nxt_rdata[kwu_pkg::SC_PEND] = pend_ff;
        nxt_rdata[kwu_pkg::SC_ACK]  = 1'b0;
        nxt_rdata[kwu_pkg::SC_IEN]  = ien_ff;
        nxt_rdata[kwu_pkg::SC_MODE] = mode_ff;
      end
      kwu_pkg::OFS_PE:  nxt_rdata[7:0] = pe_ff;
      kwu_pkg::OFS_EVT: nxt_rdata[1:0] = evt_ff;
      kwu_pkg::OFS_MSK: nxt_rdata[1:0] = msk_ff;
      default:          nxt_rdata = kwu_pkg::RST_RDATA;
    endcase
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      prdata_ff <= kwu_pkg::RST_RDATA;
    else if (rd_take)
      prdata_ff <= nxt_rdata;
  end

  // checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_all_quiet;
    CE_I && !STOP_I && !any_prev;
  endsequence

  sequence s_upper_rise;
    CE_I && !STOP_I && !mode_ff && pe_ff[7] && pol_ff[3] && !KEY_I[7] ##1
    CE_I && !STOP_I && !mode_ff && !sc_wr && KEY_I[7];
  endsequence

  sequence s_lower_fall;
    CE_I && !STOP_I && !mode_ff && pe_ff[0] && KEY_I[0] ##1
    CE_I && !STOP_I && !mode_ff && !sc_wr && !KEY_I[0];
  endsequence

  a_upper_rise_sets: assert property (s_upper_rise |=> pend_ff)
    else $error("rising edge on upper pin did not set pending");

  a_lower_fall_sets: assert property (s_lower_fall |=> pend_ff)
    else $error("falling edge on lower pin did not set pending");

  a_lower_no_rise: assert property (CE_I && !mode_ff && !any_prev && (pe_ff[7:1] == 7'h00) &&
      pe_ff[0] && KEY_I[0] && !pend_ff && !ack_wr |=> !pend_ff)
    else $error("lower pin high level set pending");

  a_pend_read_only: assert property (sc_wr && PWDATA_I[kwu_pkg::SC_PEND] && !pend_ff &&
      !pend_set |=> !pend_ff)
    else $error("pending flag written by software");

  a_ack_clears_edge: assert property (ack_wr && !mode_ff && !pend_set |=> !pend_ff)
    else $error("acknowledge in edge mode did not clear pending");

  a_ack_reads_zero: assert property (CE_I && setup && !PWRITE_I && (PADDR_I == kwu_pkg::OFS_SC)
      |=> !PRDATA_O[kwu_pkg::SC_ACK] && (PRDATA_O[kwu_pkg::SC_PEND] == $past(pend_ff)))
    else $error("status read returned wrong acknowledge or pending bit");

  a_level_holds: assert property (CE_I && mode_ff && !STOP_I && |asrt |=> pend_ff)
    else $error("pending cleared while level asserted");

  a_req_level: assert property (REQ_O == (pend_ff && ien_ff))
    else $error("request output differs from pending and enable");

  a_req_follows: assert property (CE_I && pend_set && ien_ff && !sc_wr |=> REQ_O)
    else $error("request not raised after trigger");

  a_edge_mode_quiet: assert property (CE_I && !mode_ff && !pend_ff && !edge_hit |=> !pend_ff)
    else $error("pending set without an edge in edge mode");

  a_disabled_ignored: assert property (CE_I && (pe_ff == 8'h00) && !pend_ff |=> !pend_ff)
    else $error("disabled pins set pending");

  a_level_edge_gate: assert property (mode_ff && any_prev |-> !edge_hit)
    else $error("edge counted while another pin was asserted");

  a_level_first_edge: assert property (s_all_quiet ##0 (mode_ff && |asrt) |=> pend_ff)
    else $error("first assertion in level mode missed");

  a_stop_wake: assert property (STOP_I |-> !edge_hit && (WAKE_O == |asrt))
    else $error("stop mode wake path wrong");

  a_ce_freeze_pend: assert property (!CE_I |=> $stable(pend_ff) && $stable(asrt_prev_ff) &&
      $stable(rd_held_ff))
    else $error("pending state changed while clock enable low");

  a_ce_freeze_regs: assert property (!CE_I |=> $stable(pe_ff) && $stable(pol_ff) &&
      $stable(ien_ff) && $stable(mode_ff))
    else $error("control registers changed while clock enable low");

  a_ce_freeze_evt: assert property (!CE_I |=> $stable(evt_ff) && $stable(msk_ff) &&
      $stable(prdata_ff))
    else $error("event or read data changed while clock enable low");

  a_rd_wait_data: assert property (PSEL_I && PENABLE_I && !PWRITE_I && !rd_held_ff
      |-> !PREADY_O)
    else $error("read answered before its data was latched");

  a_rd_ready_held: assert property (CE_I && PSEL_I && PENABLE_I && !PWRITE_I && rd_held_ff
      |-> PREADY_O)
    else $error("latched read not answered");

  a_wr_no_wait: assert property (CE_I && PSEL_I && PENABLE_I && PWRITE_I
      |-> PREADY_O)
    else $error("write access given a wait state");

  a_irq_level: assert property (IRQ_O ==
      |(evt_ff & msk_ff))
    else $error("interrupt output differs from masked events");

  a_wake_event: assert property (CE_I && WAKE_O
      |=> evt_ff[kwu_pkg::EVT_WAKE])
    else $error("wake did not set its event bit");

  a_trig_event: assert property (CE_I && pend_set && !pend_ff
      |=> evt_ff[kwu_pkg::EVT_TRIG])
    else $error("trigger did not set its event bit");

  a_ack_level_kept: assert property (ack_wr && mode_ff && !STOP_I && |asrt
      |=> pend_ff)
    else $error("acknowledge cleared pending while level asserted");

  a_ien_gates_req: assert property (!ien_ff
      |-> !REQ_O)
    else $error("request raised with interrupt enable low");

  a_pe_write: assert property (wr_en && (PADDR_I == kwu_pkg::OFS_PE)
      |=> pe_ff == $past(PWDATA_I[7:0]))
    else $error("pin enable write did not land");

  a_rd_zero_unmapped: assert property (rd_take && !addr_hit(PADDR_I)
      |=> PRDATA_O == kwu_pkg::RST_RDATA)
    else $error("unmapped read returned nonzero data");

endmodule

// ---- kwu_pkg.sv ----
// constants for the keypad wake unit: register map, fields, reset values
package kwu_pkg;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PIN_N    = 8;
  localparam int unsigned EVT_W    = 2;
  // register byte addresses
  localparam logic [11:0] OFS_SC   = 12'h000;
  localparam logic [11:0] OFS_PE   = 12'h004;
  localparam logic [11:0] OFS_EVT  = 12'h008;
  localparam logic [11:0] OFS_MSK  = 12'h00C;
  // keypad_status_control fields
  localparam int unsigned SC_POL_LSB = 4;
  localparam int unsigned SC_POL_MSB = 7;
  localparam int unsigned SC_PEND    = 3;
  localparam int unsigned SC_ACK     = 2;
  localparam int unsigned SC_IEN     = 1;
  localparam int unsigned SC_MODE    = 0;
  localparam int unsigned UPPER_LSB  = 4;
  // event status / mask fields
  localparam int unsigned EVT_TRIG   = 0;
  localparam int unsigned EVT_WAKE   = 1;
  // reset values
  localparam logic [3:0]  RST_POL    = 4'h0;
  localparam logic [7:0]  RST_PE     = 8'h00;
  localparam logic [1:0]  RST_EVT    = 2'h0;
  localparam logic [1:0]  RST_MSK    = 2'h0;
  localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
endpackage

// ---- kwu_keys.sv ----
// keypad switch model: turns key presses into pin levels
`timescale 1ns/1ps
module kwu_keys
(
  input  wire logic       clk_i,
  input  wire logic [7:0] press_i,
  input  wire logic [3:0] pol_i,
  output logic      [7:0] key_o
);
  logic [7:0] idle_lvl;
  // released keys rest at the deasserted level, so each press is a clean edge
  assign idle_lvl = {~pol_i, 4'hF};
  always_ff @(posedge clk_i)
  begin
    key_o <= idle_lvl ^ press_i;
  end
endmodule

// ---- tb.sv ----
// self-checking testbench for the keypad wake unit
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        ce;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  key;
  logic [7:0]  press;
  logic [3:0]  pol;
  logic        stop;
  logic        req;
  logic        wake;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          n_compared;

  kwu_top u_dut (.MCLK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .KEY_I(key), .STOP_I(stop), .REQ_O(req), .WAKE_O(wake), .IRQ_O(irq));
  kwu_keys u_keys (.clk_i(clk), .press_i(press), .pol_i(pol), .key_o(key));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 20)
      n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic keys(input logic [7:0] p);
    press <= p;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset;
    rdchk(kwu_pkg::OFS_SC, 32'h0);
    rdchk(kwu_pkg::OFS_PE, 32'h0);
    rdchk(12'h010, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask

  task automatic t_edge;
    apb(1'b1, kwu_pkg::OFS_PE, 32'h01);
    keys(8'h01);
    rdchk(kwu_pkg::OFS_SC, 32'h08);
    check({31'h0, req}, 32'h0);
    apb(1'b1, kwu_pkg::OFS_SC, 32'h02);
    rdchk(kwu_pkg::OFS_SC, 32'h0A);
    check({31'h0, req}, 32'h1);
    apb(1'b1, kwu_pkg::OFS_SC, 32'h06);
    rdchk(kwu_pkg::OFS_SC, 32'h02);
    keys(8'h02);
    rdchk(kwu_pkg::OFS_SC, 32'h02);
    keys(8'h00);
  endtask

  task automatic t_upper;
    pol <= 4'hF;
    apb(1'b1, kwu_pkg::OFS_SC, 32'hF0);
    apb(1'b1, kwu_pkg::OFS_PE, 32'h88);
    keys(8'h08);
    rdchk(kwu_pkg::OFS_SC, 32'hF8);
    keys(8'h00);
    apb(1'b1, kwu_pkg::OFS_SC, 32'hF4);
    keys(8'h80);
    rdchk(kwu_pkg::OFS_SC, 32'hF8);
    apb(1'b1, kwu_pkg::OFS_SC, 32'hF4);
    keys(8'h00);
    rdchk(kwu_pkg::OFS_SC, 32'hF0);
    apb(1'b1, kwu_pkg::OFS_PE, 32'h00);
    pol <= 4'h0;
    apb(1'b1, kwu_pkg::OFS_SC, 32'h01);
  endtask

  task automatic t_level;
    apb(1'b1, kwu_pkg::OFS_PE, 32'h01);
    keys(8'h01);
    rdchk(kwu_pkg::OFS_SC, 32'h09);
    apb(1'b1, kwu_pkg::OFS_SC, 32'h05);
    rdchk(kwu_pkg::OFS_SC, 32'h09);
    keys(8'h00);
    apb(1'b1, kwu_pkg::OFS_SC, 32'h05);
    rdchk(kwu_pkg::OFS_SC, 32'h01);
  endtask

  task automatic t_stop;
    apb(1'b1, kwu_pkg::OFS_SC, 32'h00);
    apb(1'b1, kwu_pkg::OFS_EVT, 32'h03);
    stop <= 1'b1;
    keys(8'h01);
    check({31'h0, wake}, 32'h1);
    rdchk(kwu_pkg::OFS_SC, 32'h00);
    rdchk(kwu_pkg::OFS_EVT, 32'h02);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, kwu_pkg::OFS_MSK, 32'h02);
    rdchk(kwu_pkg::OFS_MSK, 32'h02);
    check({31'h0, irq}, 32'h1);
    keys(8'h00);
    stop <= 1'b0;
    apb(1'b1, kwu_pkg::OFS_EVT, 32'h02);
    rdchk(kwu_pkg::OFS_EVT, 32'h00);
    check({31'h0, irq}, 32'h0);
  endtask

  // clock enable low freezes detection; a read started then waits for fresh data
  task automatic t_freeze;
    apb(1'b1, kwu_pkg::OFS_SC, 32'h0A);
    apb(1'b1, kwu_pkg::OFS_PE, 32'h01);
    rdchk(kwu_pkg::OFS_SC, 32'h02);
    ce <= 1'b0;
    keys(8'h01);
    check({31'h0, req}, 32'h0);
    fork
      rdchk(kwu_pkg::OFS_PE, 32'h01);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    rdchk(kwu_pkg::OFS_SC, 32'h0A);
    check({31'h0, req}, 32'h1);
    apb(1'b1, kwu_pkg::OFS_SC, 32'h06);
    keys(8'h00);
    rdchk(kwu_pkg::OFS_SC, 32'h02);
    check({31'h0, req}, 32'h0);
    apb(1'b1, kwu_pkg::OFS_PE, 32'h00);
    apb(1'b1, kwu_pkg::OFS_SC, 32'h00);
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    complete_run;
  end

  initial
  begin
    n_fail = 0;
    n_compared = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    press = 8'h00;
    pol = 4'h0;
    stop = 1'b0;
    ce = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_edge;
    t_upper;
    t_level;
    t_stop;
    t_freeze;
    complete_run;
  end
endmodule
